// file: hdl/touch_i2c_pkg.sv
// constants and types shared by the touch digitizer serial slave
package touch_i2c_pkg;
	// fixed upper address bits, followed by the two address select pins
	localparam logic [4:0] ADDR_PREFIX = 5'h12;
	// spike suppression on the bus lines
	localparam int CLK_NS = 40;
	localparam int SPIKE_NS = 50;
	localparam int FILTER_CYCLES = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
	// bit counts within a byte
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] SEL_BITS_DONE = 4'h4;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;
	// command byte fields
	localparam int CMD_SEL_MSB = 7;
	localparam int CMD_SEL_LSB = 4;
	localparam int CMD_PD_MSB = 3;
	localparam int CMD_PD_LSB = 2;
	localparam int CMD_MODE_BIT = 1;
	localparam logic [7:0] CMD_RESET = 8'h00;
	// input selector codes
	localparam logic [3:0] SEL_TEMP0 = 4'h0;
	localparam logic [3:0] SEL_BAT1 = 4'h1;
	localparam logic [3:0] SEL_TEMP1 = 4'h4;
	localparam logic [3:0] SEL_BAT2 = 4'h5;
	localparam logic [3:0] SEL_X_DRV = 4'h8;
	localparam logic [3:0] SEL_Y_DRV = 4'h9;
	localparam logic [3:0] SEL_XY_DRV = 4'ha;
	localparam logic [3:0] SEL_X_POS = 4'hc;
	localparam logic [3:0] SEL_Y_POS = 4'hd;
	localparam logic [1:0] SEL_DRV_ONLY = 2'h2;
	// high bias current is this multiple of the base current
	localparam int TEMP_BIAS_RATIO = 91;
	// read data
	localparam logic [11:0] RESULT_RESET = 12'h000;
	localparam logic [7:0] FILLER_BYTE = 8'h00;
	localparam logic [1:0] LAST_BYTE_IDX = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WRITE,
		ST_WRITE_ACK,
		ST_READ,
		ST_READ_ACK,
		ST_IGNORE
	} i2c_state_t;
endpackage

// file: hdl/bit_sync.sv
// two flip-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
	parameter int WIDTH = 1
) (
	// destination clock
	input wire logic clk,
	// asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	generate
		if (WIDTH < 1)
		begin
			$error("bit_sync needs WIDTH of at least one");
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		meta <= d;
		q <= meta;
	end
endmodule
`default_nettype wire

// file: hdl/line_filter.sv
// glitch filter: output follows input once it has been stable LEN+1 cycles
`timescale 1ns/1ps
`default_nettype none
module line_filter #(
	parameter int LEN = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// synchronised line and filtered line
	input wire logic d,
	output logic q
);
	localparam int CW = (LEN < 2) ? 1 : $clog2(LEN + 1);
	localparam logic [CW-1:0] LIMIT = CW'(LEN);
	logic [CW-1:0] stableCnt;
	wire differs = d != q;
	wire settled = stableCnt == LIMIT;

	generate
		if (LEN < 1)
		begin
			$error("line_filter needs LEN of at least one");
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			q <= 1'b1;
			stableCnt <= '0;
		end
		else if (!differs)
			stableCnt <= '0;
		else if (settled)
		begin
			q <= d;
			stableCnt <= '0;
		end
		else
			stableCnt <= stableCnt + 1'b1;
	end
endmodule
`default_nettype wire

// file: hdl/touch_i2c_slave.sv
// serial slave of the touch digitizer with acquisition control
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - slave only; scl is input only, no start or stop generated.
// - sda changing while scl high is a bus condition, never data.
// - sda falling while scl high is a start.
// - sda rising while scl high is a stop, ending the transfer.
// - eight bits per byte, then a ninth clock for acknowledge.
// - acknowledger holds sda low across the whole acknowledge high phase.
// - on writes, acknowledge matching address and the first command byte.
// - after master refusal, release sda so master can stop.
// - repeated start ends transfer and restarts address matching.
// - works at standard, fast and high-speed bus rates.
// - compare address after seven address bits plus direction bit.
// - on read direction, transmit bits on sda following master scl.
// - driver-only codes switch panel drivers on without converting.
// - code zero routes first diode at base bias current.
// - second temperature code biases diode at the larger multiple.
// - diode bias on only during temperature acquisition.
// - battery codes enable divide-by-four only during sampling.
// - address is fixed prefix, two select pins, then direction bit.
// - bytes after the first command byte are not acknowledged.
// - acquire from scl fall after last select bit until stop or restart.
module touch_i2c_slave (
	// system clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// converter clock
	input wire logic adcClk,
	// serial bus pins
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN,
	// address select straps
	input wire logic [1:0] addrSelectPin,
	// bus status
	output logic busBusy,
	// conversion result, converter clock domain
	input wire logic [11:0] resultData,
	input wire logic resultStrobe,
	// analog control, converter clock domain
	output logic [3:0] inputSelector,
	output logic acquireEn,
	output logic convStart,
	output logic xDriveEn,
	output logic yDriveEn,
	output logic crossDriveEn,
	output logic tempBiasEn,
	output logic tempBiasHigh,
	output logic batDividerEn,
	output logic [1:0] pdMode,
	output logic eightBitMode
);
	touch_i2c_pkg::i2c_state_t state;
	logic sclSync;
	logic sdaSync;
	logic [1:0] addrPins;
	logic sclF;
	logic sdaF;
	logic sclPrev;
	logic sdaPrev;
	logic [3:0] bitCnt;
	logic [7:0] shiftIn;
	logic [7:0] txShift;
	logic [1:0] byteIdx;
	logic readDir;
	logic firstByte;
	logic masterAck;
	logic sdaLow;
	logic acquire;
	logic [3:0] selReg;
	logic [7:0] cmdReg;
	logic [11:0] resultWord;
	logic togSync;
	logic togPrev;
	logic adcRst;
	logic acqSync;
	logic acqPrev;
	logic [11:0] resultHold;
	logic resultToggle;

	bit_sync #(.WIDTH(4)) lineSync (
		.clk(clk),
		.d({sclIn, sdaIn, addrSelectPin}),
		.q({sclSync, sdaSync, addrPins})
	);

	line_filter #(.LEN(touch_i2c_pkg::FILTER_CYCLES)) sclFilter (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(sclSync),
		.q(sclF)
	);

	line_filter #(.LEN(touch_i2c_pkg::FILTER_CYCLES)) sdaFilter (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(sdaSync),
		.q(sdaF)
	);

	// event toggle from the converter domain
	bit_sync #(.WIDTH(1)) resultSync (
		.clk(clk),
		.d(resultToggle),
		.q(togSync)
	);

	// reset and acquire level into the converter domain
	bit_sync #(.WIDTH(2)) adcSync (
		.clk(adcClk),
		.d({sys_rst, acquire}),
		.q({adcRst, acqSync})
	);

	// edges from oversampled lines, rate independent
	wire sclRise = sclF & ~sclPrev;
	wire sclFall = ~sclF & sclPrev;
	// sda moves with scl high are conditions
	wire sdaDuringHigh = sclF & sclPrev & (sdaF != sdaPrev);
	wire startSeen = sdaDuringHigh & ~sdaF;
	wire stopSeen = sdaDuringHigh & sdaF;
	wire [6:0] ownAddr = {touch_i2c_pkg::ADDR_PREFIX, addrPins};
	// compare after address and direction bits
	wire addrHit = shiftIn[7:1] == ownAddr;
	wire byteDone = bitCnt == touch_i2c_pkg::BITS_PER_BYTE;
	wire selLastBit = bitCnt == touch_i2c_pkg::SEL_BITS_DONE - 4'h1;
	wire selDone = bitCnt == touch_i2c_pkg::SEL_BITS_DONE;
	wire lastTxBit = bitCnt == touch_i2c_pkg::LAST_TX_BIT;
	wire [7:0] txNext = (byteIdx == 2'h0) ? resultWord[11:4] :
		(byteIdx == 2'h1) ? {resultWord[3:0], 4'h0} : touch_i2c_pkg::FILLER_BYTE;
	wire [1:0] nextIdx = (byteIdx == touch_i2c_pkg::LAST_BYTE_IDX) ? byteIdx :
		byteIdx + 2'h1;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
			togPrev <= 1'b0;
			resultWord <= touch_i2c_pkg::RESULT_RESET;
		end
		else
		begin
			sclPrev <= sclF;
			sdaPrev <= sdaF;
			togPrev <= togSync;
			if (togSync != togPrev)
				resultWord <= resultHold;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sdaOut <= 1'b0;
			sdaOeN <= 1'b1;
			busBusy <= 1'b0;
		end
		else
		begin
			sdaOut <= 1'b0;
			sdaOeN <= ~sdaLow;
			if (startSeen)
				busBusy <= 1'b1;
			else if (stopSeen)
				busBusy <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state <= touch_i2c_pkg::ST_IDLE;
			bitCnt <= 4'h0;
			shiftIn <= 8'h00;
			txShift <= 8'h00;
			byteIdx <= 2'h0;
			readDir <= 1'b0;
			firstByte <= 1'b0;
			masterAck <= 1'b0;
			sdaLow <= 1'b0;
			acquire <= 1'b0;
			selReg <= touch_i2c_pkg::SEL_TEMP0;
			cmdReg <= touch_i2c_pkg::CMD_RESET;
		end
		else if (startSeen)
		begin
			state <= touch_i2c_pkg::ST_ADDR;
			bitCnt <= 4'h0;
			byteIdx <= 2'h0;
			sdaLow <= 1'b0;
			acquire <= 1'b0;
		end
		else if (stopSeen)
		begin
			state <= touch_i2c_pkg::ST_IDLE;
			sdaLow <= 1'b0;
			acquire <= 1'b0;
		end
		else
		begin
			case (state)
				touch_i2c_pkg::ST_ADDR:
				begin
					if (sclRise)
					begin
						shiftIn <= {shiftIn[6:0], sdaF};
						bitCnt <= bitCnt + 4'h1;
					end
					else if (sclFall && byteDone)
					begin
						bitCnt <= 4'h0;
						if (addrHit)
						begin
							state <= touch_i2c_pkg::ST_ADDR_ACK;
							sdaLow <= 1'b1;
							readDir <= shiftIn[0];
						end
						else
							state <= touch_i2c_pkg::ST_IGNORE;
					end
				end
				touch_i2c_pkg::ST_ADDR_ACK:
				begin
					if (sclFall)
					begin
						if (readDir)
						begin
							state <= touch_i2c_pkg::ST_READ;
							txShift <= txNext;
							byteIdx <= nextIdx;
							sdaLow <= ~txNext[7];
						end
						else
						begin
							state <= touch_i2c_pkg::ST_WRITE;
							firstByte <= 1'b1;
							sdaLow <= 1'b0;
						end
					end
				end
				touch_i2c_pkg::ST_WRITE:
				begin
					if (sclRise)
					begin
						shiftIn <= {shiftIn[6:0], sdaF};
						bitCnt <= bitCnt + 4'h1;
						if (firstByte && selLastBit)
							selReg <= {shiftIn[2:0], sdaF};
					end
					else if (sclFall)
					begin
						// acquire from fall after last select bit
						if (firstByte && selDone)
							acquire <= 1'b1;
						if (byteDone)
						begin
							state <= touch_i2c_pkg::ST_WRITE_ACK;
							bitCnt <= 4'h0;
							sdaLow <= firstByte;
							if (firstByte)
								cmdReg <= shiftIn;
							firstByte <= 1'b0;
						end
					end
				end
				touch_i2c_pkg::ST_WRITE_ACK:
				begin
					// hold low until ninth clock falls
					if (sclFall)
					begin
						sdaLow <= 1'b0;
						state <= touch_i2c_pkg::ST_WRITE;
					end
				end
				touch_i2c_pkg::ST_READ:
				begin
					if (sclFall)
					begin
						if (lastTxBit)
						begin
							sdaLow <= 1'b0;
							bitCnt <= 4'h0;
							state <= touch_i2c_pkg::ST_READ_ACK;
						end
						else
						begin
							// next bit out on scl fall
							txShift <= {txShift[6:0], 1'b0};
							sdaLow <= ~txShift[6];
							bitCnt <= bitCnt + 4'h1;
						end
					end
				end
				touch_i2c_pkg::ST_READ_ACK:
				begin
					if (sclRise)
						masterAck <= ~sdaF;
					else if (sclFall)
					begin
						if (masterAck)
						begin
							state <= touch_i2c_pkg::ST_READ;
							txShift <= txNext;
							byteIdx <= nextIdx;
							sdaLow <= ~txNext[7];
						end
						else
						begin
							state <= touch_i2c_pkg::ST_IGNORE;
							sdaLow <= 1'b0;
						end
					end
				end
				touch_i2c_pkg::ST_IDLE,
				touch_i2c_pkg::ST_IGNORE:
					sdaLow <= 1'b0;
				default:
				begin
					state <= touch_i2c_pkg::ST_IDLE;
					sdaLow <= 1'b0;
				end
			endcase
		end
	end

	// converter side decode of the latched selector
	wire acqRise = acqSync & ~acqPrev;
	wire acqFall = ~acqSync & acqPrev;
	wire selTemp0 = selReg == touch_i2c_pkg::SEL_TEMP0;
	// second diode code uses the large current
	wire selTemp1 = selReg == touch_i2c_pkg::SEL_TEMP1;
	wire selBat = (selReg == touch_i2c_pkg::SEL_BAT1) |
		(selReg == touch_i2c_pkg::SEL_BAT2);
	wire drvX = (selReg == touch_i2c_pkg::SEL_X_DRV) |
		(selReg == touch_i2c_pkg::SEL_X_POS);
	wire drvY = (selReg == touch_i2c_pkg::SEL_Y_DRV) |
		(selReg == touch_i2c_pkg::SEL_Y_POS);
	wire drvCross = (selReg == touch_i2c_pkg::SEL_XY_DRV) |
		(selReg[3:1] == 3'h7);
	wire driverOnly = inputSelector[3:2] == touch_i2c_pkg::SEL_DRV_ONLY;

	always_ff @(posedge adcClk)
	begin
		if (adcRst)
		begin
			acqPrev <= 1'b0;
			acquireEn <= 1'b0;
			convStart <= 1'b0;
			tempBiasEn <= 1'b0;
			tempBiasHigh <= 1'b0;
			batDividerEn <= 1'b0;
			resultHold <= touch_i2c_pkg::RESULT_RESET;
			resultToggle <= 1'b0;
		end
		else
		begin
			acqPrev <= acqSync;
			acquireEn <= acqSync;
			convStart <= acqFall & ~driverOnly;
			tempBiasEn <= acqSync & (selTemp0 | selTemp1);
			tempBiasHigh <= acqSync & selTemp1;
			batDividerEn <= acqSync & selBat;
			if (resultStrobe)
			begin
				resultHold <= resultData;
				resultToggle <= ~resultToggle;
			end
		end
	end

	always_ff @(posedge adcClk)
	begin
		if (adcRst)
		begin
			inputSelector <= touch_i2c_pkg::SEL_TEMP0;
			xDriveEn <= 1'b0;
			yDriveEn <= 1'b0;
			crossDriveEn <= 1'b0;
			pdMode <= touch_i2c_pkg::CMD_RESET[touch_i2c_pkg::CMD_PD_MSB:touch_i2c_pkg::CMD_PD_LSB];
			eightBitMode <= 1'b0;
		end
		else
		begin
			if (acqRise)
			begin
				inputSelector <= selReg;
				xDriveEn <= drvX;
				yDriveEn <= drvY;
				crossDriveEn <= drvCross;
			end
			else if (resultStrobe && !pdMode[0])
			begin
				xDriveEn <= 1'b0;
				yDriveEn <= 1'b0;
				crossDriveEn <= 1'b0;
			end
			if (acqFall)
			begin
				pdMode <= cmdReg[touch_i2c_pkg::CMD_PD_MSB:touch_i2c_pkg::CMD_PD_LSB];
				eightBitMode <= cmdReg[touch_i2c_pkg::CMD_MODE_BIT];
			end
		end
	end
endmodule
`default_nettype wire

// file: dv/touch_i2c_chk.sv
// port assertions for the touch digitizer serial slave
`timescale 1ns/1ps
`default_nettype none
module touch_i2c_chk (
	// clocks and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic adcClk,
	// bus side
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOeN,
	input wire logic busBusy,
	// converter side
	input wire logic [3:0] inputSelector,
	input wire logic acquireEn,
	input wire logic convStart,
	input wire logic tempBiasEn,
	input wire logic tempBiasHigh,
	input wire logic batDividerEn
);
	wire logic drvOnly = inputSelector[3:2] == touch_i2c_pkg::SEL_DRV_ONLY;
	wire logic isBat = inputSelector == touch_i2c_pkg::SEL_BAT1
		|| inputSelector == touch_i2c_pkg::SEL_BAT2;
	a_oe_scl_low: assert property (@(posedge clk) disable iff (sys_rst)
		$changed(sdaOeN) |-> !sclIn) else $error("sda moved, scl high");
	a_ack_held: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(sdaOeN) |-> !sdaOeN [*8]) else $error("sda drive short");
	a_start_seen: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(busBusy) |-> sclIn && !sdaIn) else $error("busy, no start");
	a_stop_seen: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(busBusy) |-> sclIn && sdaIn) else $error("idle, no stop");
	a_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		!busBusy && !$past(busBusy) |-> sdaOeN) else $error("sda driven idle");
	a_bias_acq: assert property (@(posedge adcClk) disable iff (sys_rst)
		tempBiasEn |-> acquireEn || $past(acquireEn)) else $error("bias outside acquire");
	a_bias_high: assert property (@(posedge adcClk) disable iff (sys_rst)
		tempBiasHigh |-> tempBiasEn && inputSelector == touch_i2c_pkg::SEL_TEMP1)
		else $error("high bias code");
	a_bias_base: assert property (@(posedge adcClk) disable iff (sys_rst)
		tempBiasEn && !tempBiasHigh |-> inputSelector == touch_i2c_pkg::SEL_TEMP0)
		else $error("base bias code");
	a_div_window: assert property (@(posedge adcClk) disable iff (sys_rst)
		batDividerEn |-> isBat && (acquireEn || $past(acquireEn))) else $error("divider");
	a_conv_follows: assert property (@(posedge adcClk) disable iff (sys_rst)
		$fell(acquireEn) && !drvOnly |-> ##[0:5] convStart) else $error("no conversion");
	a_conv_pulse: assert property (@(posedge adcClk) disable iff (sys_rst)
		convStart |=> !convStart) else $error("start too long");
	a_drv_no_conv: assert property (@(posedge adcClk) disable iff (sys_rst)
		convStart |-> !drvOnly && !acquireEn) else $error("conversion misplaced");
	cover property (@(posedge adcClk) disable iff (sys_rst) convStart);
	cover property (@(posedge adcClk) disable iff (sys_rst) tempBiasHigh);
	cover property (@(posedge clk) disable iff (sys_rst) $fell(busBusy));
endmodule
bind touch_i2c_slave touch_i2c_chk chk_u (.clk, .sys_rst, .adcClk, .sclIn, .sdaIn, .sdaOeN,
	.busBusy, .inputSelector, .acquireEn, .convStart, .tempBiasEn, .tempBiasHigh, .batDividerEn);
`default_nettype wire

// file: dv/i2c_master_model.sv
// bus master model: drives scl, pulls sda low on demand
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	// pacing clock
	input wire logic clk,
	// bus lines
	input wire logic sdaBus,
	output logic scl,
	output logic sdaLow
);
	int halfCyc = 10;
	initial
	begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic start_cond();
		sdaLow <= 1'b0;
		hold(halfCyc);
		scl <= 1'b1;
		hold(halfCyc);
		sdaLow <= 1'b1;
		hold(halfCyc);
		scl <= 1'b0;
		hold(2);
	endtask
	task automatic stop_cond();
		sdaLow <= 1'b1;
		hold(halfCyc);
		scl <= 1'b1;
		hold(halfCyc);
		sdaLow <= 1'b0;
		hold(2 * halfCyc);
	endtask
	// nine clocks, sda moves with scl low
	task automatic xfer(input logic [7:0] tx, input logic ackOut, output logic [7:0] rx,
		output logic ackIn);
		logic [8:0] sh;
		sh = {tx, ackOut};
		for (int i = 8; i >= 0; i--)
		begin
			sdaLow <= !sh[i];
			hold(halfCyc);
			scl <= 1'b1;
			hold(halfCyc);
			sh[i] = sdaBus;
			scl <= 1'b0;
			hold(2);
		end
		rx = sh[8:1];
		ackIn = sh[0];
	endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the touch digitizer serial slave
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk;
	logic adcClk;
	logic sys_rst = 1'b1;
	logic [1:0] addrSelectPin = 2'h0;
	logic [11:0] resultData = 12'h000;
	logic resultStrobe = 1'b0;
	wire logic sclIn;
	wire logic sdaIn;
	wire logic mstSdaLow;
	logic sdaOut, sdaOeN, busBusy, acquireEn, convStart, eightBitMode;
	logic xDriveEn, yDriveEn, crossDriveEn, tempBiasEn, tempBiasHigh, batDividerEn;
	logic [3:0] inputSelector;
	logic [1:0] pdMode;
	int failCount = 0;
	int checkCount = 0;
	int seed = 32'h994a2778;
	logic [3:0] expQ [$];
	logic [7:0] rx;
	logic ack;
	logic [11:0] res;
	logic [23:0] rdExp;
	logic [7:0] cmd;
	logic [5:0] ctlTab [16] = '{6'h04, 6'h01, 6'h00, 6'h00, 6'h06, 6'h01, 6'h00, 6'h00,
		6'h20, 6'h10, 6'h08, 6'h00, 6'h20, 6'h10, 6'h08, 6'h08};
	wire logic [5:0] ctl = {xDriveEn, yDriveEn, crossDriveEn, tempBiasEn, tempBiasHigh,
		batDividerEn};
	wire logic [7:0] devAddr = {touch_i2c_pkg::ADDR_PREFIX, addrSelectPin, 1'b0};
	// open-drain sda with pull-up
	assign sdaIn = !mstSdaLow && (sdaOeN || sdaOut);
	i2c_master_model mst (.clk(clk), .sdaBus(sdaIn), .scl(sclIn), .sdaLow(mstSdaLow));
	touch_i2c_slave dut_u (.clk, .sys_rst, .adcClk, .sclIn, .sdaIn, .sdaOut, .sdaOeN,
		.addrSelectPin, .busBusy, .resultData, .resultStrobe, .inputSelector, .acquireEn,
		.convStart, .xDriveEn, .yDriveEn, .crossDriveEn, .tempBiasEn, .tempBiasHigh,
		.batDividerEn, .pdMode, .eightBitMode);
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		adcClk = 1'b0;
		#7;
		forever #62.5 adcClk = ~adcClk;
	end
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			failCount++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finalReport();
		if (failCount == 0 && checkCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge adcClk)
		if (convStart === 1'b1)
		begin
			if (expQ.size() == 0)
				check(12'h001, 12'h000);
			else
				check(12'(inputSelector), 12'(expQ.pop_front()));
		end
	initial
	begin
		@(posedge clk);
		addrSelectPin <= 2'($random(seed));
		repeat (19) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (10) @(posedge clk);
		mst.start_cond();
		mst.xfer(devAddr ^ 8'h02, 1'b1, rx, ack);
		check(12'(ack), 12'h001);
		mst.stop_cond();
		res = 12'($random(seed));
		@(posedge adcClk);
		resultData <= res;
		resultStrobe <= 1'b1;
		@(posedge adcClk);
		resultStrobe <= 1'b0;
		repeat (4) @(posedge clk);
		rdExp = {res[11:4], res[3:0], 4'h0, touch_i2c_pkg::FILLER_BYTE};
		mst.start_cond();
		mst.xfer(devAddr | 8'h01, 1'b1, rx, ack);
		check(12'(ack), 12'h000);
		// master acks all but the last byte
		for (int i = 0; i < 3; i++)
		begin
			mst.xfer(8'hff, i == 2, rx, ack);
			check(12'(rx), 12'(rdExp[23 - 8 * i -: 8]));
		end
		repeat (10) @(posedge clk);
		check(12'(sdaOeN), 12'h001);
		mst.stop_cond();
		for (int c = 0; c < 16; c++)
		begin
			mst.halfCyc = c[0] ? 7 : 20;
			mst.start_cond();
			mst.xfer(devAddr, 1'b1, rx, ack);
			check(12'(ack), 12'h000);
			cmd = {4'(c), 4'($random(seed))};
			mst.xfer(cmd, 1'b1, rx, ack);
			check(12'(ack), 12'h000);
			repeat (20) @(posedge clk);
			check(12'(acquireEn), 12'h001);
			check(12'(ctl), 12'(ctlTab[c]));
			mst.xfer(8'h5a, 1'b1, rx, ack);
			check(12'(ack), 12'h001);
			if (c[3:2] != 2'h2)
				expQ.push_back(4'(c));
			if (c == 15)
			begin
				mst.start_cond();
				check(12'(busBusy), 12'h001);
				mst.xfer(devAddr | 8'h01, 1'b1, rx, ack);
				check(12'(ack), 12'h000);
				mst.xfer(8'hff, 1'b1, rx, ack);
				check(12'(rx), 12'(res[11:4]));
			end
			mst.stop_cond();
			repeat (20) @(posedge clk);
			check(12'(ctl & 6'h07), 12'h000);
			check(12'(acquireEn), 12'h000);
			check(12'(pdMode), 12'(cmd[3:2]));
			check(12'(eightBitMode), 12'(cmd[1]));
			check(12'(busBusy), 12'h000);
			if (c inside {[8:10]})
				check(12'(ctl), 12'(ctlTab[c]));
		end
		repeat (40) @(posedge clk);
		check(12'(expQ.size()), 12'h000);
		finalReport();
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		failCount++;
		finalReport();
	end
endmodule
`default_nettype wire
